/* File: src/acp_cfg.svh */
// Constants of the converter serial control port
`ifndef ACP_CFG_SVH
`define ACP_CFG_SVH

// ***************************************************************
// Word sizes
// ***************************************************************
`define ACP_CFG_BITS 7
`define ACP_RES_BITS 12
`define ACP_CNT_BITS 4
`define ACP_SYNC_BITS 4

// ***************************************************************
// Configuration word fields, first received bit highest
// ***************************************************************
`define ACP_F_PAIRING 6
`define ACP_F_ODD_SIGN 5
`define ACP_F_SEL_HI 4
`define ACP_F_SEL_LO 3
`define ACP_F_POLARITY 2
`define ACP_F_MSB_FIRST 1
`define ACP_F_POWER_DOWN 0

// ***************************************************************
// Synchroniser lanes
// ***************************************************************
`define ACP_S_SCLK 0
`define ACP_S_CS_N 1
`define ACP_S_DIN 2
`define ACP_S_COMP 3

// ***************************************************************
// Result stream word: {mux 4, polarity 1, result 12}
// ***************************************************************
`define ACP_WORD_BITS 17
`define ACP_FIFO_DEPTH 8

// ***************************************************************
// Reset values and counts
// ***************************************************************
`define ACP_CFG_RESET 7'h00
`define ACP_RES_RESET 12'h000
`define ACP_TRIAL_FIRST 12'h800
`define ACP_CFG_LAST 4'h6
`define ACP_RES_MSB_IDX 4'hb

`endif

/* File: src/acp_pkg.sv */
// Types of the converter serial control port
package acp_pkg;

	// ***************************************************************
	// Port sequencer states, one-hot
	// ***************************************************************
	typedef enum logic [5:0] {
		ACP_ST_OFF = 6'b000001,
		ACP_ST_HUNT = 6'b000010,
		ACP_ST_CFG = 6'b000100,
		ACP_ST_NULL = 6'b001000,
		ACP_ST_DATA = 6'b010000,
		ACP_ST_DONE = 6'b100000
	} acp_state_t;

endpackage

/* File: src/acp_sync.sv */
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps

module acp_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_srst,
	// Lanes
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_sync;

	always_comb begin
		next_meta = i_async;
		next_sync = meta;
		if (i_srst) begin
			next_meta = '0;
			next_sync = '0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		meta <= next_meta;
		o_sync <= next_sync;
	end

endmodule

/* File: src/acp_fifo.sv */
// Result FIFO with valid and ready on both sides
`timescale 1ns/1ps

module acp_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_srst,
	// Fill side
	input wire logic i_wr_valid,
	input wire logic [WIDTH-1:0] i_wr_data,
	output logic o_wr_ready,
	// Drain side
	output logic o_rd_valid,
	output logic [WIDTH-1:0] o_rd_data,
	input wire logic i_rd_ready
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0] next_count;
	logic do_wr;
	logic do_rd;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		if (p == AW'(DEPTH - 1))
			return '0;
		return p + AW'(1);
	endfunction

	always_comb begin
		do_wr = i_wr_valid && o_wr_ready;
		do_rd = o_rd_valid && i_rd_ready;
		next_wr_ptr = do_wr ? ptr_inc(wr_ptr) : wr_ptr;
		next_rd_ptr = do_rd ? ptr_inc(rd_ptr) : rd_ptr;
		next_count = count;
		if (do_wr && !do_rd)
			next_count = count + (AW+1)'(1);
		else if (do_rd && !do_wr)
			next_count = count - (AW+1)'(1);
		if (i_srst) begin
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_count = '0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		wr_ptr <= next_wr_ptr;
		rd_ptr <= next_rd_ptr;
		count <= next_count;
		o_wr_ready <= (next_count != (AW+1)'(DEPTH));
		o_rd_valid <= (next_count != '0);
		if (do_wr)
			mem[wr_ptr] <= i_wr_data;
	end

	assign o_rd_data = mem[rd_ptr];

endmodule

/* File: src/acp_top.sv */
// Serial control port of a successive-approximation converter
`timescale 1ns/1ps
`include "acp_cfg.svh"

// Operation
// - Transfers only while select is low
// - Config in on data input, result out
// - Shutdown output low when power-down requested
// - Drive on falling clock, sample on rising
// - Receive whole word first, then transmit
// - Works with input and output tied
// - Select falling edge starts start-bit search
// - First one is start bit, zeros dropped
// - Seven config bits follow, start conversion
// - Ignore data input until next select cycle
// - One null bit, then result bits
// - Result belongs to this exchange's conversion
// - Select high resets port for next exchange
// - Serial clock steps the conversion
// - First four bits select multiplexer inputs
// - Polarity bit one unipolar, zero bipolar
module acp_top
	import acp_pkg::*;
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_srst,
	// Serial pins
	input wire logic i_cs_n,
	input wire logic i_sclk,
	input wire logic i_din,
	output logic o_dout,
	output logic o_dout_oe,
	output logic o_shutdown_out_n,
	// Converter core
	input wire logic i_comp_high,
	output logic [`ACP_RES_BITS-1:0] o_dac_code,
	output logic o_sample_hold,
	output logic o_conv_active,
	output logic o_input_pairing,
	output logic o_odd_sign,
	output logic [1:0] o_chan_sel,
	output logic o_polarity_select,
	// Result stream
	output logic o_res_valid,
	output logic [`ACP_WORD_BITS-1:0] o_res_data,
	input wire logic i_res_ready
);

	// ***************************************************************
	// Pin synchronisation and edge detection
	// ***************************************************************
	logic [`ACP_SYNC_BITS-1:0] pins_s;
	logic sclk_d;
	logic cs_n_d;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_high;
	logic din_s;
	logic comp_s;

	acp_sync #(
		.WIDTH(`ACP_SYNC_BITS)
	) u_sync (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.i_async({i_comp_high, i_din, i_cs_n, i_sclk}),
		.o_sync(pins_s)
	);

	always_comb begin
		din_s = pins_s[`ACP_S_DIN];
		comp_s = pins_s[`ACP_S_COMP];
		cs_high = pins_s[`ACP_S_CS_N];
		sclk_rise = pins_s[`ACP_S_SCLK] && !sclk_d;
		sclk_fall = !pins_s[`ACP_S_SCLK] && sclk_d;
		cs_fall = !pins_s[`ACP_S_CS_N] && cs_n_d;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			sclk_d <= 1'b0;
			// Match the flushed synchroniser so no false select edge follows reset
			cs_n_d <= 1'b0;
		end else begin
			sclk_d <= pins_s[`ACP_S_SCLK];
			cs_n_d <= pins_s[`ACP_S_CS_N];
		end
	end

	// ***************************************************************
	// Result FIFO
	// ***************************************************************
	logic push_pending;
	logic [`ACP_WORD_BITS-1:0] push_data;
	logic fifo_ready;

	acp_fifo #(
		.WIDTH(`ACP_WORD_BITS),
		.DEPTH(`ACP_FIFO_DEPTH)
	) u_fifo (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.i_wr_valid(push_pending),
		.i_wr_data(push_data),
		.o_wr_ready(fifo_ready),
		.o_rd_valid(o_res_valid),
		.o_rd_data(o_res_data),
		.i_rd_ready(i_res_ready)
	);

	// ***************************************************************
	// Successive-approximation step
	// ***************************************************************
	function automatic logic [`ACP_RES_BITS-1:0] sar_step(
		input logic [`ACP_RES_BITS-1:0] trial,
		input logic [`ACP_CNT_BITS-1:0] idx,
		input logic keep
	);
		logic [`ACP_RES_BITS-1:0] t;
		t = trial;
		t[idx] = keep;
		if (idx != '0)
			t[idx - `ACP_CNT_BITS'(1)] = 1'b1;
		return t;
	endfunction

	// ***************************************************************
	// Sequencer state
	// ***************************************************************
	acp_state_t state;
	acp_state_t next_state;
	logic [`ACP_CNT_BITS-1:0] bit_cnt;
	logic [`ACP_CNT_BITS-1:0] next_bit_cnt;
	logic [`ACP_CFG_BITS-1:0] cfg_sr;
	logic [`ACP_CFG_BITS-1:0] next_cfg_sr;
	logic [`ACP_CFG_BITS-1:0] cfg_word;
	logic [`ACP_CFG_BITS-1:0] next_cfg_word;
	logic [`ACP_RES_BITS-1:0] trial;
	logic [`ACP_RES_BITS-1:0] next_trial;
	logic [`ACP_RES_BITS-1:0] result;
	logic [`ACP_RES_BITS-1:0] next_result;
	logic next_dout;
	logic next_dout_oe;
	logic next_shutdown_n;
	logic next_sample_hold;
	logic next_conv_active;
	logic next_push_pending;
	logic [`ACP_WORD_BITS-1:0] next_push_data;
	logic [`ACP_CFG_BITS-1:0] full_cfg;

	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_cfg_sr = cfg_sr;
		next_cfg_word = cfg_word;
		next_trial = trial;
		next_result = result;
		next_dout = o_dout;
		next_dout_oe = o_dout_oe;
		next_shutdown_n = o_shutdown_out_n;
		next_sample_hold = o_sample_hold;
		next_conv_active = o_conv_active;
		next_push_pending = push_pending;
		next_push_data = push_data;
		full_cfg = {cfg_sr[`ACP_CFG_BITS-2:0], din_s};

		// Hand a finished word to the FIFO
		if (push_pending && fifo_ready)
			next_push_pending = 1'b0;

		case (state)
			ACP_ST_OFF: begin
				if (cs_fall)
					next_state = ACP_ST_HUNT;
			end
			ACP_ST_HUNT: begin
				// Stall start-bit search while a result waits for room
				if (sclk_rise && din_s && !next_push_pending) begin
					next_state = ACP_ST_CFG;
					next_bit_cnt = '0;
					next_cfg_sr = `ACP_CFG_RESET;
					next_sample_hold = 1'b0;
				end
			end
			ACP_ST_CFG: begin
				if (sclk_rise) begin
					next_cfg_sr = full_cfg;
					next_bit_cnt = bit_cnt + `ACP_CNT_BITS'(1);
					if (bit_cnt == `ACP_CFG_LAST) begin
						next_cfg_word = full_cfg;
						next_shutdown_n = !full_cfg[`ACP_F_POWER_DOWN];
						next_trial = `ACP_TRIAL_FIRST;
						next_result = `ACP_RES_RESET;
						next_state = ACP_ST_NULL;
					end
				end
			end
			ACP_ST_NULL: begin
				if (sclk_fall) begin
					next_dout_oe = 1'b1;
					next_dout = 1'b0;
					next_sample_hold = 1'b1;
					next_conv_active = 1'b1;
					next_bit_cnt = `ACP_RES_MSB_IDX;
					next_state = ACP_ST_DATA;
				end
			end
			ACP_ST_DATA: begin
				// Each falling edge decides and sends one bit
				if (sclk_fall) begin
					next_dout = comp_s;
					next_result = result;
					next_result[bit_cnt] = comp_s;
					next_trial = sar_step(trial, bit_cnt, comp_s);
					if (bit_cnt == '0) begin
						next_conv_active = 1'b0;
						next_push_pending = 1'b1;
						next_push_data = {cfg_word[`ACP_F_PAIRING:`ACP_F_POLARITY], next_result};
						next_state = ACP_ST_DONE;
					end else begin
						next_bit_cnt = bit_cnt - `ACP_CNT_BITS'(1);
					end
				end
			end
			ACP_ST_DONE: begin
				// Trailing clocks see zeros; data input is ignored
				if (sclk_fall)
					next_dout = 1'b0;
			end
			default: begin
				next_state = ACP_ST_OFF;
			end
		endcase

		// Select high ends any exchange and frees the line
		if (cs_high) begin
			next_state = ACP_ST_OFF;
			next_dout_oe = 1'b0;
			next_dout = 1'b0;
			next_conv_active = 1'b0;
			next_sample_hold = 1'b0;
			next_bit_cnt = '0;
		end

		if (i_srst) begin
			next_state = ACP_ST_OFF;
			next_bit_cnt = '0;
			next_cfg_sr = `ACP_CFG_RESET;
			next_cfg_word = `ACP_CFG_RESET;
			next_trial = `ACP_RES_RESET;
			next_result = `ACP_RES_RESET;
			next_dout = 1'b0;
			next_dout_oe = 1'b0;
			next_shutdown_n = 1'b1;
			next_sample_hold = 1'b0;
			next_conv_active = 1'b0;
			next_push_pending = 1'b0;
			next_push_data = '0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		state <= next_state;
		bit_cnt <= next_bit_cnt;
		cfg_sr <= next_cfg_sr;
		cfg_word <= next_cfg_word;
		trial <= next_trial;
		result <= next_result;
		o_dout <= next_dout;
		o_dout_oe <= next_dout_oe;
		o_shutdown_out_n <= next_shutdown_n;
		o_sample_hold <= next_sample_hold;
		o_conv_active <= next_conv_active;
		push_pending <= next_push_pending;
		push_data <= next_push_data;
	end

	// ***************************************************************
	// Converter core controls
	// ***************************************************************
	always_ff @(posedge i_sys_clk) begin
		o_dac_code <= next_trial;
		o_input_pairing <= next_cfg_word[`ACP_F_PAIRING];
		o_odd_sign <= next_cfg_word[`ACP_F_ODD_SIGN];
		o_chan_sel <= next_cfg_word[`ACP_F_SEL_HI:`ACP_F_SEL_LO];
		o_polarity_select <= next_cfg_word[`ACP_F_POLARITY];
	end

endmodule

/* File: tb/acp_top_assertions.sv */
// Pin-level checks of the converter serial port
`timescale 1ns/1ps
`include "acp_cfg.svh"

module acp_checker (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_srst,
	// Serial pins
	input wire logic i_cs_n,
	input wire logic i_sclk,
	input wire logic o_dout,
	input wire logic o_dout_oe,
	input wire logic o_shutdown_out_n,
	// Converter and stream
	input wire logic o_sample_hold,
	input wire logic o_conv_active,
	input wire logic o_res_valid,
	input wire logic [`ACP_WORD_BITS-1:0] o_res_data,
	input wire logic i_res_ready
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	logic sclk_q;
	logic next_sclk_q;
	logic [4:0] n_fall;
	logic [4:0] next_n_fall;
	// Clock falls seen while the device drives
	always_comb begin
		next_sclk_q = i_sclk;
		next_n_fall = n_fall;
		if (i_srst || !o_dout_oe)
			next_n_fall = 5'h00;
		else if (sclk_q && !i_sclk)
			next_n_fall = n_fall + 5'h01;
	end
	always_ff @(posedge i_sys_clk) begin
		sclk_q <= next_sclk_q;
		n_fall <= next_n_fall;
	end
	sequence s_idle;
		i_cs_n [*6];
	endsequence
	sequence s_null_start;
		$rose(o_dout_oe);
	endsequence
	property p_oe_off;
		s_idle |-> !o_dout_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("driving while deselected");
	property p_null;
		s_null_start |-> !o_dout && o_sample_hold;
	endproperty
	a_null: assert property (p_null) else $error("null bit wrong");
	property p_conv;
		$rose(o_conv_active) |-> s_null_start;
	endproperty
	a_conv: assert property (p_conv) else $error("conversion not at null bit");
	property p_edge;
		o_dout_oe && $changed(o_dout) |-> !i_sclk;
	endproperty
	a_edge: assert property (p_edge) else $error("output changed with clock high");
	property p_bits;
		$fell(o_conv_active) |-> n_fall == 5'h0c;
	endproperty
	a_bits: assert property (p_bits) else $error("result bit count wrong");
	property p_sso;
		$changed(o_shutdown_out_n) |-> !o_dout_oe && !i_cs_n;
	endproperty
	a_sso: assert property (p_sso) else $error("shutdown changed out of place");
	property p_sel;
		s_null_start |-> !$past(i_cs_n, 4);
	endproperty
	a_sel: assert property (p_sel) else $error("answer without select");
	property p_res;
		o_res_valid && !i_res_ready |=> o_res_valid && $stable(o_res_data);
	endproperty
	a_res: assert property (p_res) else $error("held result lost");
endmodule

bind acp_top acp_checker u_chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_cs_n(i_cs_n),
	.i_sclk(i_sclk), .o_dout(o_dout), .o_dout_oe(o_dout_oe), .o_shutdown_out_n(o_shutdown_out_n),
	.o_sample_hold(o_sample_hold), .o_conv_active(o_conv_active), .o_res_valid(o_res_valid),
	.o_res_data(o_res_data), .i_res_ready(i_res_ready));

/* File: tb/acp_host.sv */
// Host serial master driving select, clock and data
`timescale 1ns/1ps

module acp_host (
	// Clock
	input wire logic i_sys_clk,
	// Serial wire
	input wire logic i_line,
	output logic o_cs_n,
	output logic o_sclk,
	output logic o_data
);
	localparam int PH = 8;
	logic busy = 1'b1;
	logic drv = 1'b0;
	logic fill = 1'b0;
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
	end
	// Released line toggles every cycle
	always @(negedge i_sys_clk) fill <= ~fill;
	assign o_data = busy ? drv : fill;
	task automatic wt(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask
	// Exchange; fewer than 8 word bits aborts
	task automatic xfer(input logic [6:0] cfg, input int zeros, input int nbits, output logic [12:0] rx);
		logic [7:0] word;
		word = {1'b1, cfg};
		busy = 1'b1;
		drv = 1'b0;
		rx = 13'h0000;
		o_cs_n = 1'b0;
		wt(PH);
		for (int i = 0; i < zeros + nbits; i++) begin
			drv = (i < zeros) ? 1'b0 : word[7 - (i - zeros)];
			wt(PH);
			o_sclk = 1'b1;
			wt(PH);
			o_sclk = 1'b0;
		end
		busy = 1'b0;
		if (nbits == 8) begin
			for (int i = 12; i >= 0; i--) begin
				wt(PH);
				o_sclk = 1'b1;
				rx[i] = i_line;
				wt(PH);
				o_sclk = 1'b0;
			end
		end
		wt(PH);
		o_cs_n = 1'b1;
		wt(PH);
	endtask
endmodule

/* File: tb/adc_serial_control_port_tb.sv */
// Self-checking bench for the converter serial port
`timescale 1ns/1ps

module adc_serial_control_port_tb;
	logic i_sys_clk = 1'b0;
	logic i_srst = 1'b1;
	logic i_res_ready = 1'b1;
	logic comp = 1'b0;
	logic [11:0] ain = 12'h000;
	logic cs_n, sclk, host_data, line, dout, oe, sso_n, res_valid;
	logic [11:0] dac;
	logic [4:0] mux;
	logic [16:0] res_data;
	int n_mismatch = 0;
	int checks = 0;

	always #2 i_sys_clk = ~i_sys_clk;
	assign line = oe ? dout : host_data;
	// Comparator of the analog input
	always @(negedge i_sys_clk) comp <= (ain >= dac) === 1'b1;

	acp_host u_host (.i_sys_clk(i_sys_clk), .i_line(line), .o_cs_n(cs_n), .o_sclk(sclk), .o_data(host_data));
	acp_top u_dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(line),
		.o_dout(dout), .o_dout_oe(oe), .o_shutdown_out_n(sso_n), .i_comp_high(comp), .o_dac_code(dac),
		.o_sample_hold(), .o_conv_active(), .o_input_pairing(mux[4]), .o_odd_sign(mux[3]),
		.o_chan_sel(mux[2:1]), .o_polarity_select(mux[0]), .o_res_valid(res_valid),
		.o_res_data(res_data), .i_res_ready(i_res_ready));

	task automatic cmp(input logic [16:0] got, input logic [16:0] want, input string what);
		checks++;
		if (got !== want) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, want);
		end
	endtask
	task automatic run(input logic [6:0] cfg, input logic [11:0] a, input int zeros);
		logic [12:0] rx;
		ain = a;
		u_host.xfer(cfg, zeros, 8, rx);
		cmp(17'(rx[12]), 17'h00000, "null");
		cmp(17'(rx[11:0]), 17'(a), "result");
		cmp(17'(mux), 17'(cfg[6:2]), "fields");
		cmp(17'(sso_n), 17'(!cfg[0]), "shutdown");
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_modes;
		for (int i = 0; i < 16; i++)
			run({4'(i), ~i[0], 2'b00}, 12'(i * 273), i % 3);
	endtask
	task automatic t_shutdown;
		run(7'h01, 12'habc, 0);
		run(7'h00, 12'h543, 1);
	endtask
	task automatic t_abort;
		logic [12:0] rx;
		u_host.xfer(7'h7f, 0, 4, rx);
		run(7'h24, 12'h3c5, 2);
	endtask
	task automatic t_fifo;
		logic [16:0] wexp [8];
		logic [12:0] rx;
		i_res_ready = 1'b0;
		for (int i = 0; i < 8; i++) begin
			wexp[i] = {5'(i * 5), 12'(i * 499)};
			ain = wexp[i][11:0];
			u_host.xfer({wexp[i][16:12], 2'b00}, 0, 8, rx);
		end
		cmp(17'(res_valid), 17'h00001, "held");
		for (int i = 0; i < 8; i++) begin
			cmp(res_data, wexp[i], "word");
			i_res_ready = 1'b1;
			u_host.wt(1);
			i_res_ready = 1'b0;
			u_host.wt(3);
		end
		cmp(17'(res_valid), 17'h00000, "empty");
		i_res_ready = 1'b1;
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (20) @(negedge i_sys_clk);
		i_srst = 1'b0;
		u_host.wt(5);
		t_modes();
		t_shutdown();
		t_abort();
		t_fifo();
		finish_test();
	end
	initial begin
		#200000;
		n_mismatch++;
		finish_test();
	end
endmodule
